/* File: shared/fag_consts.svh */
// constants for the flash access guard
`ifndef FAG_CONSTS_SVH
`define FAG_CONSTS_SVH
`define FAG_OFF_PROGRAM_STORE_CONTROL      8'h8F
`define FAG_OFF_FCTL       8'hB7
`define FAG_OFF_FLOOR      8'hB8
`define FAG_OFF_ADDR       8'hB9
`define FAG_RST_PROGRAM_STORE_CONTROL      8'h00
`define FAG_RST_FCTL       8'h80
`define FAG_RST_FLOOR      8'h00
`define FAG_BIT_MODIFY     0
`define FAG_BIT_STWE       0
`define FAG_BIT_PGERASE    1
`define FAG_BIT_SCRATCH    2
`define FAG_RW_LO          4
`define FAG_RW_HI          5
`define FAG_FLOOR_LSB      9
`define FAG_BLOCK_LSB      14
`define FAG_PAGE_LSB       10
`define FAG_SEC_PAGE       7'h7E
`define FAG_SEC_WE_ADDR    17'h1FBFE
`define FAG_SEC_RD_ADDR    17'h1FBFF
`define FAG_RSV_BASE       17'h1FC00
`define FAG_TOP_BLOCK      7
`define FAG_SCR_LIMIT      17'h000FF
`define FAG_SCR_ERASE      17'h00400
`define FAG_JUNK_DATA      8'hFF
`define FAG_BYTE_ZERO      8'h00
`endif

/* File: shared/fag_pkg.sv */
// types of the flash access guard
package fag_pkg;
   typedef enum logic [1:0] {
      FAG_OP_READ,
      FAG_OP_WRITE,
      FAG_OP_ERASE,
      FAG_OP_CODE
   } fag_op_t;

   typedef struct packed {
      logic        valid;
      logic        from_jtag;
      fag_op_t     op;
      logic [16:0] addr;
      logic [16:0] pc;
      logic [7:0]  wdata;
   } fag_req_t;

   typedef struct packed {
      logic        valid;
      logic        grant;
      logic        to_xram;
      logic        to_scratch;
      logic        erase_page;
      logic        erase_scratch;
      logic        full_erase;
      logic        mask_data;
   } fag_resp_t;
endpackage : fag_pkg

/* File: rtl/fag_guard.sv */
// flash access guard: lock bytes, access floor and flash control bits
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "fag_consts.svh"
module fag_guard
   import fag_pkg::*;
#(
   parameter int ADDR_W = 17
) (
   // clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   // lock bytes as stored in flash
   input  wire logic [7:0]  read_lock_in,
   input  wire logic [7:0]  write_lock_in,
   // access request and decision
   input  wire fag_req_t    req_in,
   output fag_resp_t        resp_out,
   // raw flash data and guarded data
   input  wire logic [7:0]  flash_rdata_in,
   output logic      [7:0]  guard_rdata_out,
   // read timing select to the flash engine
   output logic      [1:0]  read_wait_select_out
);

   initial begin
      if (ADDR_W != 17) begin
         $error("fag_guard serves only a 17-bit flash address");
      end
   end

   typedef struct packed {
      logic [1:0]  read_wait_select;
      logic        flash_modify_enable;
      logic        scratch_select;
      logic        page_erase_enable;
      logic        store_write_enable;
      logic [7:0]  access_floor;
      logic        floor_written;
      logic [7:0]  rdata;
      logic [7:0]  guard_rdata;
      fag_resp_t   resp;
   } fag_state_t;

   fag_state_t st_reg;
   fag_state_t st_next;

   function automatic logic [2:0] block_of(input logic [16:0] a);
      block_of = a[`FAG_BLOCK_LSB+2:`FAG_BLOCK_LSB];
   endfunction : block_of

   function automatic logic sec_page(input logic [16:0] a);
      sec_page = (a[16:`FAG_PAGE_LSB] == `FAG_SEC_PAGE);
   endfunction : sec_page

   ////////////////////////////////////////////////////////////////////
   // decision terms
   logic [16:0] floor_addr;
   logic        upper_code;
   logic        below_floor;
   logic        is_reserved;
   logic        rd_ok_jtag;
   logic        we_ok_jtag;
   logic        sec_target;
   logic        is_write;
   logic        is_erase;

   assign floor_addr  = {st_reg.access_floor, {`FAG_FLOOR_LSB{1'b0}}};
   assign upper_code  = (req_in.pc >= floor_addr);
   assign below_floor = (req_in.addr < floor_addr);
   assign is_reserved = (req_in.addr >= `FAG_RSV_BASE);
   assign sec_target  = (req_in.addr == `FAG_SEC_WE_ADDR) ||
                        (req_in.addr == `FAG_SEC_RD_ADDR);
   assign is_write    = (req_in.op == FAG_OP_WRITE);
   assign is_erase    = (req_in.op == FAG_OP_ERASE);
   assign rd_ok_jtag  = read_lock_in[block_of(req_in.addr)];
   assign we_ok_jtag  = write_lock_in[block_of(req_in.addr)];

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic ok;
      logic to_xram;
      logic scr;
      logic sec_pg;
      ok      = 1'b0;
      to_xram = 1'b0;
      scr     = 1'b0;
      sec_pg  = sec_page(req_in.addr);
      st_next = st_reg;
      st_next.rdata = `FAG_BYTE_ZERO;
      st_next.resp  = '0;

      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `FAG_OFF_PROGRAM_STORE_CONTROL: begin
               st_next.scratch_select     = reg_wdata_in[`FAG_BIT_SCRATCH];
               st_next.page_erase_enable  = reg_wdata_in[`FAG_BIT_PGERASE];
               st_next.store_write_enable = reg_wdata_in[`FAG_BIT_STWE];
            end
            `FAG_OFF_FCTL: begin
               st_next.read_wait_select =
                  reg_wdata_in[`FAG_RW_HI:`FAG_RW_LO];
               st_next.flash_modify_enable = reg_wdata_in[`FAG_BIT_MODIFY];
            end
            `FAG_OFF_FLOOR: begin
               if (!st_reg.floor_written) begin
                  st_next.access_floor  = reg_wdata_in;
                  st_next.floor_written = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `FAG_OFF_PROGRAM_STORE_CONTROL: st_next.rdata = {5'h00,
               st_reg.scratch_select, st_reg.page_erase_enable,
               st_reg.store_write_enable};
            `FAG_OFF_FCTL: st_next.rdata = {2'h2,
               st_reg.read_wait_select, 3'h0, st_reg.flash_modify_enable};
            `FAG_OFF_FLOOR: st_next.rdata = st_reg.access_floor;
            `FAG_OFF_ADDR: st_next.rdata = {7'h00, st_reg.floor_written};
            default: st_next.rdata = `FAG_BYTE_ZERO;
         endcase
      end

      if (req_in.from_jtag) begin
         unique case (req_in.op)
            FAG_OP_READ, FAG_OP_CODE: begin
               ok = rd_ok_jtag || sec_target;
            end
            FAG_OP_WRITE: begin
               // top locked, security bytes still writable
               ok = we_ok_jtag || sec_target;
            end
            FAG_OP_ERASE: begin
               // locked page only by full erase
               ok = we_ok_jtag || sec_target;
            end
         endcase
         // scratchpad locked when whole byte clear
         if (st_reg.scratch_select) begin
            ok = (req_in.op == FAG_OP_READ) ? (read_lock_in != 8'h00)
                                            : (write_lock_in != 8'h00);
         end
         if (is_reserved) begin
            ok = 1'b0;
         end
      end else begin
         scr = st_reg.scratch_select;
         // data writes steer to xram or flash
         to_xram = is_write && !st_reg.store_write_enable;
         // upper code kept out of lower partition, except for code fetches
         ok = !(upper_code && below_floor &&
                (req_in.op != FAG_OP_CODE) && !scr);
         if ((is_write || is_erase) && !to_xram) begin
            ok = ok && st_reg.flash_modify_enable &&
                 st_reg.store_write_enable;
         end
         // security page never erased by firmware
         if (is_erase || (is_write && st_reg.page_erase_enable)) begin
            ok = ok && !(sec_pg && !scr);
         end
         if (scr && req_in.addr > `FAG_SCR_LIMIT &&
             req_in.addr != `FAG_SCR_ERASE) begin
            ok = 1'b0;
         end
         if (is_reserved && !scr) begin
            ok = 1'b0;
         end
         if (to_xram) begin
            ok = 1'b1;
         end
      end

      if (req_in.valid) begin
         st_next.resp.valid      = 1'b1;
         st_next.resp.grant      = ok;
         st_next.resp.to_xram    = to_xram;
         st_next.resp.to_scratch = scr && !req_in.from_jtag;
         // granted jtag erases clear their page too, except at a security byte
         st_next.resp.erase_page = ok && !to_xram &&
            !(req_in.from_jtag && sec_target) && (is_erase ||
            (is_write && st_reg.page_erase_enable && !req_in.from_jtag));
         st_next.resp.erase_scratch = st_next.resp.erase_page && scr &&
            (req_in.addr == `FAG_SCR_ERASE);
         // jtag erase at a security byte
         st_next.resp.full_erase = req_in.from_jtag && is_erase &&
            sec_target && !is_reserved;
         if (req_in.from_jtag && is_erase && sec_target) begin
            st_next.resp.grant = 1'b1;
         end
         st_next.resp.mask_data = !req_in.from_jtag &&
            (req_in.op == FAG_OP_READ) && upper_code && below_floor && !scr;
      end
      st_next.guard_rdata = st_next.resp.mask_data ? `FAG_JUNK_DATA
                                                   : flash_rdata_in;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
         st_reg.read_wait_select <= 2'h0;
      end else if (clk_en_in) begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_out        = st_reg.rdata;
   assign resp_out             = st_reg.resp;
   assign guard_rdata_out      = st_reg.guard_rdata;
   assign read_wait_select_out = st_reg.read_wait_select;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_floor_write;
      reg_wr_in && clk_en_in && reg_addr_in == `FAG_OFF_FLOOR;
   endsequence

   chk_floor_once: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_floor_write and st_reg.floor_written |=>
         $stable(st_reg.access_floor))
      else $error("floor changed after first write");

   chk_floor_take: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_floor_write and !st_reg.floor_written |=>
         floor_addr == {$past(reg_wdata_in), 9'h000})
      else $error("floor not taken");

   chk_jtag_rlock: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && req_in.from_jtag &&
      req_in.op == FAG_OP_READ && !rd_ok_jtag && !sec_target &&
      !st_reg.scratch_select |=> !resp_out.grant)
      else $error("jtag read of locked block granted");

   chk_jtag_wlock: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && req_in.from_jtag && is_write &&
      !we_ok_jtag && !sec_target && !st_reg.scratch_select
      |=> !resp_out.grant)
      else $error("jtag write of locked block granted");

   chk_jtag_erase: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && req_in.from_jtag && is_erase &&
      we_ok_jtag && !sec_target && !is_reserved && !st_reg.scratch_select
      |=> resp_out.grant && resp_out.erase_page)
      else $error("unlocked jtag page erase refused");

   chk_full_erase: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && req_in.from_jtag && is_erase &&
      sec_target |=> resp_out.grant && resp_out.full_erase)
      else $error("jtag erase at security byte not a device erase");

   chk_rsv_block: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && is_reserved && !sec_target &&
      !(st_reg.scratch_select && !req_in.from_jtag) |=> !resp_out.grant)
      else $error("reserved area granted");

   chk_modify_gate: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && !req_in.from_jtag && is_erase &&
      !st_reg.flash_modify_enable |=> !resp_out.grant)
      else $error("erase without modify enable");

   chk_sec_erase: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && !req_in.from_jtag && is_erase &&
      sec_page(req_in.addr) && !st_reg.scratch_select
      |=> !resp_out.grant)
      else $error("firmware erased security page");

   chk_upper_mask: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && !req_in.from_jtag &&
      req_in.op == FAG_OP_READ && upper_code && below_floor &&
      !st_reg.scratch_select |=> guard_rdata_out == `FAG_JUNK_DATA)
      else $error("lower partition data leaked");

   chk_fetch_ok: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req_in.valid && !req_in.from_jtag &&
      req_in.op == FAG_OP_CODE && !is_reserved && !st_reg.scratch_select
      |=> resp_out.grant)
      else $error("fetch refused");

   chk_ctrl_zero: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && reg_rd_in && reg_addr_in == `FAG_OFF_FCTL
      |=> reg_rdata_out[3:1] == 3'h0)
      else $error("reserved control bits nonzero");

endmodule : fag_guard

/* File: test/fag_host_model.sv */
// requester model: core and debugger issuing flash accesses
`timescale 1ns/10ps
module fag_host_model
   import fag_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // request side
   output fag_req_t        req_out,
   output logic      [7:0] flash_rdata_out,
   // decision side
   input  wire fag_resp_t  resp_in,
   input  wire logic [7:0] guard_rdata_in
);
   initial begin
      req_out = '0;
      flash_rdata_out = 8'h5A;
   end
   ////////////////////////////////////////////////////////////////////
   // callers keep scratch range, jtag-only full erase
   // no cache here, so read wait may drop at any time
   task automatic send(input logic jt, input fag_op_t op,
                       input logic [16:0] addr, input logic [16:0] pc,
                       output fag_resp_t rsp, output logic [7:0] rd);
      @(posedge clk_in);
      req_out <= '{1'b1, jt, op, addr, pc, 8'h3C};
      flash_rdata_out <= 8'hA5;
      @(posedge clk_in);
      // released lines show the inverse, except op, which keeps its value
      req_out <= '{1'b0, ~jt, op, ~addr, ~pc, 8'hC3};
      flash_rdata_out <= 8'h5A;
      #1;
      rsp = resp_in;
      rd = guard_rdata_in;
   endtask : send
endmodule : fag_host_model

/* File: test/fag_guard_tb_top.sv */
// testbench for the flash access guard
`timescale 1ns/10ps
module fag_guard_tb_top
   import fag_pkg::*;
;
   typedef struct packed {
      logic [7:0]  pst;
      logic [15:0] locks;
      logic        jt;
      fag_op_t     op;
      logic [16:0] addr;
      logic [16:0] pc;
      logic [6:0]  exp;
      logic [6:0]  care;
   } fag_row_t;
   localparam logic [16:0] LO = 17'h03E00;
   localparam logic [16:0] UP = 17'h04000;
   // resp bits: grant xram scratch erase_pg erase_scr full mask
   localparam fag_row_t ROWS [0:25] = '{
      '{8'h00,16'hFEFF,1'b1,FAG_OP_READ,17'h00010,UP,7'h00,7'h40},
      '{8'h00,16'hFEFF,1'b1,FAG_OP_READ,17'h04010,UP,7'h40,7'h40},
      '{8'h00,16'hFFFB,1'b1,FAG_OP_WRITE,17'h08000,UP,7'h00,7'h4A},
      '{8'h00,16'hFFFF,1'b1,FAG_OP_WRITE,17'h08000,UP,7'h40,7'h40},
      '{8'h00,16'hFFFF,1'b1,FAG_OP_ERASE,17'h08000,UP,7'h48,7'h4A},
      '{8'h00,16'hFF7F,1'b1,FAG_OP_ERASE,17'h1FBFE,UP,7'h42,7'h42},
      '{8'h00,16'h007F,1'b1,FAG_OP_WRITE,17'h1FBFE,UP,7'h40,7'h40},
      '{8'h00,16'h007F,1'b1,FAG_OP_READ,17'h1FBFF,UP,7'h40,7'h40},
      '{8'h00,16'hFF7F,1'b1,FAG_OP_ERASE,17'h1F800,UP,7'h00,7'h4A},
      '{8'h00,16'hFFFF,1'b1,FAG_OP_ERASE,17'h1F800,UP,7'h48,7'h4A},
      '{8'h00,16'hFFFF,1'b1,FAG_OP_READ,17'h1FC00,UP,7'h00,7'h40},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h1FC00,LO,7'h00,7'h40},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h00100,UP,7'h01,7'h01},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h04100,LO,7'h40,7'h41},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h00100,LO,7'h40,7'h41},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_CODE,17'h00100,UP,7'h40,7'h41},
      '{8'h01,16'hFFFF,1'b0,FAG_OP_WRITE,17'h00100,UP,7'h00,7'h4A},
      '{8'h01,16'hFFFF,1'b0,FAG_OP_WRITE,17'h08000,LO,7'h40,7'h68},
      '{8'h00,16'hFFFF,1'b0,FAG_OP_WRITE,17'h08000,LO,7'h60,7'h60},
      '{8'h03,16'hFFFF,1'b0,FAG_OP_WRITE,17'h08000,LO,7'h48,7'h68},
      '{8'h03,16'hFFFF,1'b0,FAG_OP_WRITE,17'h1F800,LO,7'h00,7'h4A},
      '{8'h01,16'h0000,1'b0,FAG_OP_WRITE,17'h1FBFE,LO,7'h40,7'h40},
      '{8'h03,16'hFFFF,1'b0,FAG_OP_ERASE,17'h00100,UP,7'h00,7'h4A},
      '{8'h05,16'hFFFF,1'b0,FAG_OP_WRITE,17'h00010,UP,7'h50,7'h50},
      '{8'h07,16'hFFFF,1'b0,FAG_OP_WRITE,17'h00400,LO,7'h44,7'h44},
      '{8'h03,16'hFFFF,1'b0,FAG_OP_ERASE,17'h1F800,LO,7'h00,7'h4A}
   };
   logic            clk_in;
   logic            rst_n_in;
   logic            clk_en_in;
   logic            reg_wr_in;
   logic            reg_rd_in;
   logic      [7:0] reg_addr_in;
   logic      [7:0] reg_wdata_in;
   logic      [7:0] reg_rdata_out;
   logic      [7:0] rd_lock;
   logic      [7:0] wr_lock;
   logic      [7:0] flash_rdata;
   logic      [7:0] guard_rdata;
   logic      [1:0] rws;
   fag_req_t        req;
   fag_resp_t       resp;
   int              errors;
   int              tests_run;
   int              cycles;
   fag_guard u_fag_guard (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .read_lock_in(rd_lock), .write_lock_in(wr_lock), .req_in(req),
      .resp_out(resp), .flash_rdata_in(flash_rdata),
      .guard_rdata_out(guard_rdata), .read_wait_select_out(rws));
   fag_host_model u_fag_host_model (.clk_in(clk_in), .req_out(req),
      .flash_rdata_out(flash_rdata), .resp_in(resp),
      .guard_rdata_in(guard_rdata));
   ////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk_byte(input string what, input logic [7:0] e,
                           input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk_byte
   task automatic chk_resp(input logic [6:0] e, input logic [6:0] c,
                           input fag_resp_t g);
      tests_run++;
      if ({g.valid, g[6:0] & c} !== {1'b1, e & c}) begin
         errors++;
         $display("ERROR resp expected %h seen %h", e & c, g);
      end
   endtask : chk_resp
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : reg_wr
   task automatic rchk(input string what, input logic [7:0] a,
                       input logic [7:0] e);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk_byte(what, e, reg_rdata_out);
   endtask : rchk
   task automatic access(input fag_row_t r);
      fag_resp_t  rsp;
      logic [7:0] rd;
      u_fag_host_model.send(r.jt, r.op, r.addr, r.pc, rsp, rd);
      chk_resp(r.exp, r.care, rsp);
      if (r.care[0]) begin
         chk_byte("guard data", r.exp[0] ? 8'hFF : 8'hA5, rd);
      end
   endtask : access
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // run is about 170 cycles; the ceiling leaves wide margin
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      {errors, tests_run, cycles} = '0;
      {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      clk_en_in = 1'b1;
      rd_lock = 8'hFF;
      wr_lock = 8'hFF;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rchk("store ctrl reset", 8'h8F, 8'h00);
      rchk("flash ctrl reset", 8'hB7, 8'h80);
      rchk("floor reset", 8'hB8, 8'h00);
      access('{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h00100,UP,7'h40,7'h41});
      rchk("unmapped read", 8'h00, 8'h00);
      reg_wr(8'h8F, 8'hFF);
      rchk("store ctrl bits", 8'h8F, 8'h07);
      for (int i = 3; i >= 0; i--) begin
         reg_wr(8'hB7, {2'b00, i[1:0], 4'h1});
         #1;
         chk_byte("read wait", {6'h00, i[1:0]}, {6'h00, rws});
         rchk("flash ctrl", 8'hB7, {2'h2, i[1:0], 4'h1});
      end
      reg_wr(8'hB7, 8'h0F);
      rchk("ctrl reserved", 8'hB7, 8'h81);
      reg_wr(8'hB8, 8'h20);
      rchk("floor written", 8'hB9, 8'h01);
      reg_wr(8'hB8, 8'h40);
      rchk("floor once", 8'hB8, 8'h20);
      foreach (ROWS[i]) begin
         reg_wr(8'h8F, ROWS[i].pst);
         rd_lock <= ROWS[i].locks[15:8];
         wr_lock <= ROWS[i].locks[7:0];
         access(ROWS[i]);
      end
      // modify enable off must stop software writes
      reg_wr(8'hB7, 8'h00);
      reg_wr(8'h8F, 8'h01);
      access('{8'h01,16'hFFFF,1'b0,FAG_OP_WRITE,17'h08000,LO,7'h00,7'h4A});
      access('{8'h01,16'hFFFF,1'b0,FAG_OP_ERASE,17'h08000,LO,
               7'h00,7'h4A});
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rchk("floor rereset", 8'hB8, 8'h00);
      reg_wr(8'hB8, 8'h40);
      rchk("floor rewrite", 8'hB8, 8'h40);
      access('{8'h00,16'hFFFF,1'b0,FAG_OP_READ,17'h00100,UP,7'h40,7'h41});
      stop_test();
   end
endmodule : fag_guard_tb_top
